// [src/cpm_pkg.sv]
// Package for the cyclic process-data mapper: register map, format table, defaults.
// Assumes a single 10 MHz APB clock domain.
`default_nettype none
package cpm_pkg;
    // APB register byte offsets
    localparam logic [11:0] CPM_CTRL_OFS = 12'h000;
    localparam logic [11:0] CPM_STAT_OFS = 12'h004;
    localparam logic [11:0] CPM_CMD_OFS = 12'h008;
    localparam logic [11:0] CPM_SPD_OFS = 12'h00c;
    localparam logic [11:0] CPM_DSTAT_OFS = 12'h010;
    localparam logic [11:0] CPM_OFREQ_OFS = 12'h014;
    localparam logic [11:0] CPM_OUTMAP_OFS = 12'h040;
    localparam logic [11:0] CPM_INMAP_OFS = 12'h080;
    localparam logic [11:0] CPM_OUTDAT_OFS = 12'h0c0;
    localparam logic [11:0] CPM_INDAT_OFS = 12'h100;
    localparam logic [11:0] CPM_FIFO_OFS = 12'h140;
    // Control fields
    localparam int CPM_CTRL_FMT_LSB = 0;
    localparam int CPM_CTRL_PROF_LSB = 4;
    localparam int CPM_CTRL_RELAX_BIT = 8;
    localparam logic [2:0] CPM_FMT_RST = 3'h1;
    localparam logic [3:0] CPM_PROF_RST = 4'h0;
    localparam int CPM_SLOTS = 10;
    localparam int CPM_FORMATS = 5;
    localparam int CPM_FIFO_DEPTH = 32;
    // Process-data word count per format (1..5), index 0 unused
    localparam logic [3:0] CPM_FMT_WORDS [0:5] = '{4'h0, 4'h2, 4'h6, 4'h2, 4'h6, 4'ha};
    // Parameter channel present per format
    localparam logic [5:0] CPM_FMT_PCH = 6'b100110;
    typedef enum logic [1:0] {CPM_IDLE, CPM_OUT, CPM_IN} cpm_state_t;
endpackage : cpm_pkg
`default_nettype wire

// [src/cpm_fifo.sv]
// Synchronous FIFO for received output words (slot index in top bits).
// Assumes one clock; valid/ready handshakes on both sides.
`default_nettype none
module cpm_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q];

    // Storage array, no reset needed
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : cpm_fifo
`default_nettype wire

// [src/cpm_slot_map.sv]
// Slot address resolver: picks mapped register or default/ignore per slot.
// Assumes map settings are held stable in the caller's registers.
`default_nettype none
module cpm_slot_map (
    input wire logic [3:0] slot,
    input wire logic [15:0] map_sel,
    input wire logic is_output,
    input wire logic [15:0] dflt_addr0,
    input wire logic [15:0] dflt_addr1,
    output logic use_default,
    output logic use_zero,
    output logic [15:0] target
);
    // Slots 0,1 fall back to the default words; later slots ignore or return zero
    always_comb begin
        use_default = (map_sel == 16'h0000) && (slot < 4'h2);
        use_zero = (map_sel == 16'h0000) && (slot >= 4'h2);
        if (map_sel != 16'h0000) begin
            target = map_sel;
        end else if (slot == 4'h0) begin
            target = dflt_addr0;
        end else begin
            target = dflt_addr1;
        end
        if (is_output && use_zero) begin
            target = 16'h0000;
        end
    end
endmodule : cpm_slot_map
`default_nettype wire

// [src/cpm_mapper.sv]
// Cyclic process-data mapper top: APB registers, per-slot mapping, drive bus port.
// Assumes a synchronous fieldbus exchange strobe and a one-cycle drive register bus.
//
// Our own choices: the APB register port and the register addresses.
`default_nettype none
// What this block does
// - Five selectable exchange formats fix word count and parameter channel presence.
// - Every format carries command word and speed reference word outputs.
// - Every format returns status word and output frequency word inputs.
// - Twenty map settings, ten output slots and ten input slots, give addresses.
// - Zero map on slot one or two selects the default word.
// - Relax setting lifts the run-editable restriction on output mapping.
// - Zero-mapped slots three to ten: output ignored, input returns zero.
// - Command and status appear in slot one only when both maps zero.
module cpm_mapper
    import cpm_pkg::*;
#(
    parameter int SLOTS = CPM_SLOTS,
    parameter int FIFO_DEPTH = CPM_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xchg_strobe,
    input wire logic run_active,
    output logic xchg_busy,
    output logic drv_wr,
    output logic drv_rd,
    output logic [15:0] drv_addr,
    output logic [15:0] drv_wdata,
    input wire logic [15:0] drv_rdata,
    input wire logic [15:0] drv_editable,
    output logic map_reject
);
    localparam logic [15:0] CMD_ADDR = 16'hfff0;
    localparam logic [15:0] SPD_ADDR = 16'hfff1;
    localparam logic [15:0] DST_ADDR = 16'hfff2;
    localparam logic [15:0] OFR_ADDR = 16'hfff3;

    logic [2:0] fmt_q;
    logic [3:0] prof_q;
    logic relax_q;
    logic [15:0] out_map_q [0:SLOTS-1];
    logic [15:0] in_map_q [0:SLOTS-1];
    logic [15:0] out_dat_q [0:SLOTS-1];
    logic [15:0] in_dat_q [0:SLOTS-1];
    logic [15:0] cmd_q;
    logic [15:0] spd_q;
    logic [15:0] dstat_q;
    logic [15:0] ofreq_q;
    logic [7:0] reject_cnt_q;
    cpm_state_t st_q;
    logic [3:0] slot_q;
    logic wr_en;
    logic rd_en;
    logic fmt_ok;
    logic [3:0] nwords;
    logic o_dflt, o_zero, i_dflt, i_zero;
    logic [15:0] o_tgt, i_tgt;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [19:0] fifo_out_data;
    logic edit_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign fmt_ok = (fmt_q >= 3'h1) && (fmt_q <= 3'(CPM_FORMATS));
    assign nwords = (fmt_ok && prof_q == 4'h0) ? CPM_FMT_WORDS[fmt_q] : 4'h0;
    assign xchg_busy = (st_q != CPM_IDLE);

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q <= CPM_FMT_RST;
            prof_q <= CPM_PROF_RST;
            relax_q <= 1'b0;
        end else if (wr_en && paddr == CPM_CTRL_OFS) begin
            fmt_q <= pwdata[CPM_CTRL_FMT_LSB +: 3];
            prof_q <= pwdata[CPM_CTRL_PROF_LSB +: 4];
            relax_q <= pwdata[CPM_CTRL_RELAX_BIT];
        end
    end

    // twenty map settings and received output words
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_map_q[g] <= 16'h0000;
                    in_map_q[g] <= 16'h0000;
                    out_dat_q[g] <= 16'h0000;
                end else begin
                    if (wr_en && paddr == CPM_OUTMAP_OFS + 12'(4 * g)) begin
                        out_map_q[g] <= pwdata[15:0];
                    end
                    if (wr_en && paddr == CPM_INMAP_OFS + 12'(4 * g)) begin
                        in_map_q[g] <= pwdata[15:0];
                    end
                    if (wr_en && paddr == CPM_OUTDAT_OFS + 12'(4 * g)) begin
                        out_dat_q[g] <= pwdata[15:0];
                    end
                end
            end
        end
    endgenerate

    // Read mux; registered so prdata comes from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= 32'h0000_0000;
            if (paddr == CPM_CTRL_OFS) begin
                prdata <= {23'h0, relax_q, prof_q, 1'b0, fmt_q};
            end else if (paddr == CPM_STAT_OFS) begin
                prdata <= {16'h0, reject_cnt_q, 3'h0, CPM_FMT_PCH[fmt_q],
                    nwords};
            end else if (paddr == CPM_CMD_OFS) begin
                prdata <= {16'h0, cmd_q};
            end else if (paddr == CPM_SPD_OFS) begin
                prdata <= {16'h0, spd_q};
            end else if (paddr == CPM_DSTAT_OFS) begin
                prdata <= {16'h0, dstat_q};
            end else if (paddr == CPM_OFREQ_OFS) begin
                prdata <= {16'h0, ofreq_q};
            end else if (paddr == CPM_FIFO_OFS) begin
                prdata <= {31'h0, fifo_out_valid};
            end else begin
                for (int i = 0; i < SLOTS; i++) begin
                    if (paddr == CPM_OUTMAP_OFS + 12'(4 * i)) begin
                        prdata <= {16'h0, out_map_q[i]};
                    end
                    if (paddr == CPM_INMAP_OFS + 12'(4 * i)) begin
                        prdata <= {16'h0, in_map_q[i]};
                    end
                    if (paddr == CPM_OUTDAT_OFS + 12'(4 * i)) begin
                        prdata <= {16'h0, out_dat_q[i]};
                    end
                    if (paddr == CPM_INDAT_OFS + 12'(4 * i)) begin
                        prdata <= {16'h0, in_dat_q[i]};
                    end
                end
            end
        end
    end

    // Slot resolvers for the current output and input slot
    cpm_slot_map u_omap (
        .slot(slot_q),
        .map_sel(out_map_q[slot_q]),
        .is_output(1'b1),
        .dflt_addr0(CMD_ADDR),
        .dflt_addr1(SPD_ADDR),
        .use_default(o_dflt),
        .use_zero(o_zero),
        .target(o_tgt)
    );
    cpm_slot_map u_imap (
        .slot(slot_q),
        .map_sel(in_map_q[slot_q]),
        .is_output(1'b0),
        .dflt_addr0(DST_ADDR),
        .dflt_addr1(OFR_ADDR),
        .use_default(i_dflt),
        .use_zero(i_zero),
        .target(i_tgt)
    );

    // slot one defaults need both slot-one maps zero, else ignore or return zero
    logic slot1_dflt_ok;
    logic o_skip;
    logic i_blank;
    logic [3:0] rd_slot_q;
    assign slot1_dflt_ok = (out_map_q[0] == 16'h0000) && (in_map_q[0] == 16'h0000);
    assign o_skip = o_zero || (o_dflt && slot_q == 4'h0 && !slot1_dflt_ok);
    assign i_blank = i_zero || (i_dflt && slot_q == 4'h0 && !slot1_dflt_ok);

    // Exchange sequencer: output pass then input pass, one slot a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= CPM_IDLE;
            slot_q <= 4'h0;
        end else begin
            unique case (st_q)
                CPM_IDLE: begin
                    if (xchg_strobe && nwords != 4'h0) begin
                        st_q <= CPM_OUT;
                        slot_q <= 4'h0;
                    end
                end
                CPM_OUT: begin
                    // Back-pressure from the FIFO holds the slot
                    if (fifo_in_ready) begin
                        if (slot_q == nwords - 4'h1) begin
                            st_q <= CPM_IN;
                            slot_q <= 4'h0;
                        end else begin
                            slot_q <= slot_q + 4'h1;
                        end
                    end
                end
                CPM_IN: begin
                    if (slot_q == nwords - 4'h1) begin
                        st_q <= CPM_IDLE;
                        slot_q <= 4'h0;
                    end else begin
                        slot_q <= slot_q + 4'h1;
                    end
                end
                default: st_q <= CPM_IDLE;
            endcase
        end
    end

    assign fifo_in_valid = (st_q == CPM_OUT) && !o_skip;
    // Output words queued with their slot index; drained to drive bus one per cycle
    cpm_fifo #(
        .WIDTH(20),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({slot_q, out_dat_q[slot_q]}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // edit restriction lifted by relax bit or when stopped
    logic [15:0] drain_tgt;
    assign drain_tgt = (out_map_q[fifo_out_data[19:16]] != 16'h0000)
        ? out_map_q[fifo_out_data[19:16]]
        : ((fifo_out_data[19:16] == 4'h0) ? CMD_ADDR : SPD_ADDR);
    assign edit_ok = relax_q || !run_active || drv_editable[0]
        || (drain_tgt == CMD_ADDR) || (drain_tgt == SPD_ADDR);
    // Drain only while the input pass is not using the drive bus
    assign fifo_out_ready = (st_q != CPM_IN);

    // write output words, read input words over the drive port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_wr <= 1'b0;
            drv_rd <= 1'b0;
            drv_addr <= 16'h0000;
            drv_wdata <= 16'h0000;
            rd_slot_q <= 4'h0;
        end else begin
            drv_wr <= fifo_out_valid && fifo_out_ready && edit_ok;
            drv_rd <= (st_q == CPM_IN) && !i_zero && !i_dflt;
            if (st_q == CPM_IN) begin
                drv_addr <= i_tgt;
            end else begin
                drv_addr <= drain_tgt;
            end
            drv_wdata <= fifo_out_data[15:0];
            // Remember which slot the pending read belongs to
            rd_slot_q <= slot_q;
        end
    end

    // default command and speed words latch from output slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= 16'h0000;
            spd_q <= 16'h0000;
            reject_cnt_q <= 8'h00;
        end else if (fifo_out_valid && fifo_out_ready) begin
            if (!edit_ok) begin
                reject_cnt_q <= reject_cnt_q + 8'h01;
            end else if (drain_tgt == CMD_ADDR) begin
                cmd_q <= fifo_out_data[15:0];
            end else if (drain_tgt == SPD_ADDR) begin
                spd_q <= fifo_out_data[15:0];
            end
        end
    end
    assign map_reject = fifo_out_valid && fifo_out_ready && !edit_ok;

    // Drive status and output frequency words set by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dstat_q <= 16'h0000;
            ofreq_q <= 16'h0000;
        end else begin
            if (wr_en && paddr == CPM_DSTAT_OFS) begin
                dstat_q <= pwdata[15:0];
            end
            if (wr_en && paddr == CPM_OFREQ_OFS) begin
                ofreq_q <= pwdata[15:0];
            end
        end
    end

    // input slot refresh: default, zero or drive data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SLOTS; i++) begin
                in_dat_q[i] <= 16'h0000;
            end
        end else begin
            // Drive data is only valid while the registered read pulse stands
            if (drv_rd) begin
                in_dat_q[rd_slot_q] <= drv_rdata;
            end
            if (st_q == CPM_IN) begin
                if (i_blank) begin
                    in_dat_q[slot_q] <= 16'h0000;
                end else if (i_dflt) begin
                    in_dat_q[slot_q] <= (slot_q == 4'h0) ? dstat_q : ofreq_q;
                end
            end
        end
    end

    zero_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == CPM_IN && i_zero) |=> in_dat_q[$past(slot_q)] == 16'h0000)
        else $error("zero-mapped input slot not zero");
    status_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == CPM_IN && slot_q == 4'h0 && in_map_q[0] == 16'h0000
        && out_map_q[0] == 16'h0000)
        |=> in_dat_q[0] == $past(dstat_q)) else $error("status word missing");
    freq_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == CPM_IN && slot_q == 4'h1 && in_map_q[1] == 16'h0000)
        |=> in_dat_q[1] == $past(ofreq_q)) else $error("frequency word missing");
    word_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        xchg_busy |-> slot_q < nwords) else $error("slot beyond format");
    profile_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == CPM_IDLE && prof_q != 4'h0) |=> st_q == CPM_IDLE)
        else $error("exchange with profile nonzero");
    relax_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        relax_q |-> !map_reject) else $error("reject while relaxed");
    // input read issued for mapped slot
    mapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == CPM_IN && in_map_q[slot_q] != 16'h0000)
        |=> drv_rd && drv_addr == $past(in_map_q[slot_q])) else $error("no read");
    cmd_default_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fifo_out_valid && fifo_out_ready && edit_ok && drain_tgt == CMD_ADDR)
        |=> cmd_q == $past(fifo_out_data[15:0])) else $error("command lost");
    cov_exchange_c: cover property (@(posedge pclk) st_q == CPM_IN && slot_q == 4'h9);
    cov_full_c: cover property (@(posedge pclk) st_q == CPM_OUT && !fifo_in_ready);
    cov_reject_c: cover property (@(posedge pclk) map_reject);
endmodule : cpm_mapper
`default_nettype wire

// [tb/cpm_drive_model.sv]
// Drive register space model standing behind the mapper's drive-side bus.
// Assumes one-cycle write pulses and read data taken while the read pulse is high.
`default_nettype none
module cpm_drive_model (
    input wire logic pclk,
    input wire logic drv_wr,
    input wire logic drv_rd,
    input wire logic [15:0] drv_addr,
    input wire logic [15:0] drv_wdata,
    output logic [15:0] drv_rdata,
    output logic [15:0] drv_editable,
    input wire logic lock_edit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [logic [15:0]];

    // Registers never written read as zero
    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 16'h0000;
    endfunction : peek

    // Outside a read the lines change with the address, so stale data cannot pass
    assign drv_rdata = (drv_rd === 1'b1) ? peek(drv_addr) : ~drv_addr;

    assign drv_editable = lock_edit ? 16'h0000 : 16'hffff;

    // Writes land on the edge that sees the pulse
    always @(posedge pclk) begin
        if (drv_wr === 1'b1) begin
            mem[drv_addr] = drv_wdata;
        end
    end
endmodule : cpm_drive_model
`default_nettype wire

// [tb/test_cyclic_process_data_mapper.sv]
// Self-checking bench for the mapper: APB tasks, exchanges, drive model readback.
// Assumes zero-wait APB and a drained FIFO before results are read.
`default_nettype none
module test_cyclic_process_data_mapper;
    import cpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, xchg_strobe = 0, run_active = 0, xchg_busy;
    logic drv_wr, drv_rd, map_reject, lock_edit = 0;
    logic [15:0] drv_addr, drv_wdata, drv_rdata, drv_editable;
    int n_mismatch = 0, checked = 0, n_stray = 0;

    cpm_mapper uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xchg_strobe(xchg_strobe), .run_active(run_active),
        .xchg_busy(xchg_busy), .drv_wr(drv_wr), .drv_rd(drv_rd), .drv_addr(drv_addr),
        .drv_wdata(drv_wdata), .drv_rdata(drv_rdata), .drv_editable(drv_editable),
        .map_reject(map_reject));
    cpm_drive_model u_drv (.pclk(pclk), .drv_wr(drv_wr), .drv_rd(drv_rd),
        .drv_addr(drv_addr), .drv_wdata(drv_wdata), .drv_rdata(drv_rdata),
        .drv_editable(drv_editable), .lock_edit(lock_edit));

    // 10 MHz clock
    initial begin
        forever #50 pclk = ~pclk;
    end

    // A word from an unmapped slot must never reach the drive
    always @(posedge pclk) begin
        if (drv_wr === 1'b1 && drv_wdata === 16'h7777) n_stray++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rchk

    // One exchange, then wait for the sequencer and the FIFO drain
    task automatic xchg();
        xchg_strobe <= 1;
        @(posedge pclk);
        xchg_strobe <= 0;
        @(posedge pclk);
        while (xchg_busy !== 1'b0) @(posedge pclk);
        do begin
            apb(0, CPM_FIFO_OFS, 32'h0);
        end while (rd[0] !== 1'b0);
        repeat (3) @(posedge pclk);
    endtask : xchg

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Watchdog: the tests need well under 3000 cycles
    initial begin
        #2000000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        u_drv.mem[16'h0200] = 16'h3c3c;
        u_drv.mem[16'h0400] = 16'h0bad;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rchk("ctrl reset", CPM_CTRL_OFS, 32'h00000001);
        for (int f = 1; f <= 5; f++) begin
            apb(1, CPM_CTRL_OFS, f);
            apb(0, CPM_STAT_OFS, 32'h0);
            chk("words", {28'h0, rd[3:0]}, {28'h0, CPM_FMT_WORDS[f]});
            chk("param channel", {31'h0, rd[4]}, {31'h0, f inside {1, 2, 5}});
        end
        apb(1, 12'h3fc, 32'h0000ffff);
        rchk("unmapped", 12'h3fc, 32'h0);
        apb(1, CPM_CTRL_OFS, 32'h00000002);
        apb(1, CPM_DSTAT_OFS, 32'h00001234);
        apb(1, CPM_OFREQ_OFS, 32'h00000567);
        apb(1, CPM_OUTDAT_OFS, 32'h0000047f);
        apb(1, CPM_OUTDAT_OFS + 12'h004, 32'h00000fa0);
        // double word low then high, distinct targets
        apb(1, CPM_OUTMAP_OFS + 12'h008, 32'h00000120);
        apb(1, CPM_OUTMAP_OFS + 12'h00c, 32'h00000121);
        apb(1, CPM_OUTDAT_OFS + 12'h008, 32'h0000aaaa);
        apb(1, CPM_OUTDAT_OFS + 12'h00c, 32'h00005555);
        apb(1, CPM_OUTDAT_OFS + 12'h010, 32'h00007777);
        apb(1, CPM_INMAP_OFS + 12'h008, 32'h00000200);
        xchg();
        rchk("command", CPM_CMD_OFS, 32'h0000047f);
        rchk("speed", CPM_SPD_OFS, 32'h00000fa0);
        rchk("status in", CPM_INDAT_OFS, 32'h00001234);
        rchk("freq in", CPM_INDAT_OFS + 12'h004, 32'h00000567);
        chk("low half", {16'h0, u_drv.peek(16'h0120)}, 32'h0000aaaa);
        chk("high half", {16'h0, u_drv.peek(16'h0121)}, 32'h00005555);
        rchk("mapped in", CPM_INDAT_OFS + 12'h008, 32'h00003c3c);
        rchk("zero in", CPM_INDAT_OFS + 12'h010, 32'h0);
        chk("ignored out", n_stray, 0);
        // Slot one remapped: command register must keep its value
        apb(1, CPM_OUTMAP_OFS, 32'h00000300);
        apb(1, CPM_OUTDAT_OFS, 32'h00001111);
        xchg();
        rchk("command kept", CPM_CMD_OFS, 32'h0000047f);
        chk("slot one mapped", {16'h0, u_drv.peek(16'h0300)}, 32'h00001111);
        rchk("status blanked", CPM_INDAT_OFS, 32'h0);
        apb(1, CPM_OUTMAP_OFS, 32'h0);
        // locked register refused while running, accepted once relaxed
        run_active <= 1;
        lock_edit <= 1;
        apb(1, CPM_OUTMAP_OFS + 12'h008, 32'h00000400);
        apb(1, CPM_OUTDAT_OFS + 12'h008, 32'h00002222);
        xchg();
        chk("locked kept", {16'h0, u_drv.peek(16'h0400)}, 32'h00000bad);
        apb(0, CPM_STAT_OFS, 32'h0);
        chk("reject counted", {24'h0, rd[15:8]}, 32'h2);
        apb(1, CPM_CTRL_OFS, 32'h00000102);
        xchg();
        chk("relaxed write", {16'h0, u_drv.peek(16'h0400)}, 32'h00002222);
        // Nonzero profile: no words exchanged and a strobe starts nothing
        apb(1, CPM_CTRL_OFS, 32'h00000112);
        rchk("profile words", CPM_STAT_OFS, 32'h00000210);
        xchg_strobe <= 1;
        @(posedge pclk);
        xchg_strobe <= 0;
        @(posedge pclk);
        chk("profile gate", {31'h0, xchg_busy}, 32'h0);
        print_verdict();
    end
endmodule : test_cyclic_process_data_mapper
`default_nettype wire
